// >>> arcfg_pkg.sv
// shared constants for the rate and reference configuration block
//
// Overview of operation
// - rate_select bits 7:5 choose output rate
// - rate codes map to per-mode sample rates
// - rates flagged as scaled when external clock frequency differs
// - mode field bits 4:3 selects normal/duty/turbo
// - bit 2 selects single-shot or continuous
// - temp sensor overrides mux, gain, bypass
// - bit 0 switches burn-out sources
// - bits 7:6 select conversion reference
// - bits 5:4 select line rejection filter
// - bit 3 sets low-side switch behaviour
// - bits 2:0 set excitation current magnitude
// - registers at 01h and 02h, reset 00h
package arcfg_pkg;
    localparam logic [1:0] OFS_CONV_SETUP = 2'h1;
    localparam logic [1:0] OFS_REF_SETUP = 2'h2;
    localparam logic [7:0] RST_CONV_SETUP = 8'h00;
    localparam logic [7:0] RST_REF_SETUP = 8'h00;
    localparam int RATE_MSB = 7;
    localparam int RATE_LSB = 5;
    localparam int MODE_MSB = 4;
    localparam int MODE_LSB = 3;
    localparam int KIND_BIT = 2;
    localparam int TEMP_BIT = 1;
    localparam int BURN_BIT = 0;
    localparam int REF_MSB = 7;
    localparam int REF_LSB = 6;
    localparam int REJ_MSB = 5;
    localparam int REJ_LSB = 4;
    localparam int SW_BIT = 3;
    localparam int EXC_MSB = 2;
    localparam int EXC_LSB = 0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_DUTY = 2'h1;
    localparam logic [1:0] MODE_TURBO = 2'h2;
    // rates in quarter-SPS at 4.096 MHz reference clock
    localparam logic [15:0] RATE_NORMAL_Q [0:6] = '{16'h0050, 16'h00b4, 16'h0168, 16'h02bc,
                                                   16'h0528, 16'h0960, 16'h0fa0};
    localparam logic [15:0] RATE_DUTY_Q [0:6] = '{16'h0014, 16'h002d, 16'h005a, 16'h00b0,
                                                 16'h014a, 16'h0258, 16'h03e8};
    // excitation magnitudes in uA, index is code
    localparam logic [10:0] EXC_UA [0:7] = '{11'h000, 11'h000, 11'h032, 11'h064,
                                            11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc};
    localparam logic [10:0] BURNOUT_UA = 11'h00a;
    localparam int REF_CLK_KHZ = 4096;
endpackage

// >>> arcfg_decode.sv
// decode of latched settings into rate and current figures
module arcfg_decode (
    input wire logic [2:0] rate_code, // rate_select
    input wire logic [1:0] mode_code, // operating mode
    input wire logic [2:0] exc_code, // excitation_current_set
    output logic [15:0] rate_q, // rate in quarter-SPS
    output logic [10:0] exc_ua, // excitation per source, uA
    output logic code_bad // unused encoding seen
);
    always_comb begin
        rate_q = 16'h0000;
        if (rate_code != 3'h7) begin
            case (mode_code)
                arcfg_pkg::MODE_NORMAL: rate_q = arcfg_pkg::RATE_NORMAL_Q[rate_code];
                arcfg_pkg::MODE_DUTY: rate_q = arcfg_pkg::RATE_DUTY_Q[rate_code];
                arcfg_pkg::MODE_TURBO: rate_q = {arcfg_pkg::RATE_NORMAL_Q[rate_code][14:0], 1'b0};
                default: rate_q = 16'h0000;
            endcase
        end
        exc_ua = arcfg_pkg::EXC_UA[exc_code];
        code_bad = (rate_code == 3'h7) || (mode_code == 2'h3) || (exc_code == 3'h1);
    end
endmodule // arcfg_decode

// >>> arcfg_regs.sv
// configuration registers with avalon slave and conversion-time latching
module arcfg_regs #(
    parameter int EXT_CLK_KHZ = 4096
) (
    input wire logic CLK, // 250 MHz clock
    input wire logic SYS_RST, // async reset, high
    input wire logic [1:0] AVS_ADDRESS, // word address
    input wire logic AVS_READ, // read strobe
    input wire logic AVS_WRITE, // write strobe
    input wire logic [31:0] AVS_WRITEDATA, // write data
    input wire logic [3:0] AVS_BYTEENABLE, // byte enables
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // wait request
    output logic AVS_RESPONSE_ERR, // unmapped access
    input wire logic EXT_CLK_SEL, // external clock in use
    input wire logic CONV_BEGIN, // begin_convert_cmd pulse
    input wire logic SLEEP_CMD, // sleep_cmd pulse
    input wire logic CONV_DONE, // conversion finished pulse
    output logic [2:0] RATE_SEL, // active rate_select
    output logic [1:0] OP_MODE, // active mode
    output logic [15:0] RATE_QSPS, // active rate quarter-SPS
    output logic RATE_SCALED, // rate scaled by ext clock
    output logic MOD_CLK_FAST, // 512 kHz modulator
    output logic DUTY_CYCLE_ON, // 1:4 duty operation
    output logic CONT_CONV, // continuous conversion
    output logic TEMP_SENSE, // temperature sensor mode
    output logic USE_MUX_CFG, // mux/gain/bypass honoured
    output logic BURNOUT_ON, // burn-out sources on
    output logic [10:0] BURNOUT_UA, // burn-out current uA
    output logic [1:0] REF_SEL, // reference source
    output logic FORCE_INT_REF, // internal reference forced
    output logic [1:0] LINE_REJ, // FIR rejection choice
    output logic LOWSIDE_CLOSED, // low-side switch closed
    output logic [10:0] EXC_UA_OUT, // excitation per source
    output logic CFG_INVALID, // unused code active
    output logic REJ_MISUSE, // rejection at wrong rate
    output logic BUSY // conversion in progress
);
    logic [7:0] conv_setup_reg;
    logic [7:0] ref_setup_reg;
    logic [7:0] act_conv_reg;
    logic [7:0] act_ref_reg;
    logic busy_reg;
    logic wait_reg;
    logic [15:0] rate_q;
    logic [10:0] exc_ua;
    logic code_bad;
    logic hit;

    assign hit = (AVS_ADDRESS == arcfg_pkg::OFS_CONV_SETUP) || (AVS_ADDRESS == arcfg_pkg::OFS_REF_SETUP);

    // one wait cycle, then acknowledge
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wait_reg <= 1'b1;
        end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end
    assign AVS_WAITREQUEST = wait_reg;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            conv_setup_reg <= arcfg_pkg::RST_CONV_SETUP;
            ref_setup_reg <= arcfg_pkg::RST_REF_SETUP;
        end else if (AVS_WRITE && !wait_reg && AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == arcfg_pkg::OFS_CONV_SETUP) begin
                conv_setup_reg <= AVS_WRITEDATA[7:0];
            end
            if (AVS_ADDRESS == arcfg_pkg::OFS_REF_SETUP) begin
                ref_setup_reg <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // read data registered during wait cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            AVS_READDATA <= 32'h0000_0000;
            AVS_RESPONSE_ERR <= 1'b0;
        end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
            AVS_RESPONSE_ERR <= !hit;
            case (AVS_ADDRESS)
                arcfg_pkg::OFS_CONV_SETUP: AVS_READDATA <= {24'h000000, conv_setup_reg};
                arcfg_pkg::OFS_REF_SETUP: AVS_READDATA <= {24'h000000, ref_setup_reg};
                default: AVS_READDATA <= 32'h0000_0000;
            endcase
        end else begin
            AVS_RESPONSE_ERR <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            act_conv_reg <= arcfg_pkg::RST_CONV_SETUP;
            act_ref_reg <= arcfg_pkg::RST_REF_SETUP;
        end else if (!busy_reg || (CONV_DONE && act_conv_reg[arcfg_pkg::KIND_BIT])) begin
            act_conv_reg <= conv_setup_reg;
            act_ref_reg <= ref_setup_reg;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            busy_reg <= 1'b0;
        end else if (SLEEP_CMD) begin
            busy_reg <= 1'b0;
        end else if (CONV_BEGIN) begin
            busy_reg <= 1'b1;
        end else if (CONV_DONE && !act_conv_reg[arcfg_pkg::KIND_BIT]) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            LOWSIDE_CLOSED <= 1'b0;
        end else if (!ref_setup_reg[arcfg_pkg::SW_BIT]) begin
            LOWSIDE_CLOSED <= 1'b0;
        end else if (SLEEP_CMD) begin
            LOWSIDE_CLOSED <= 1'b0;
        end else if (CONV_BEGIN) begin
            LOWSIDE_CLOSED <= 1'b1;
        end
    end

    arcfg_decode u_decode (
        .rate_code(act_conv_reg[arcfg_pkg::RATE_MSB:arcfg_pkg::RATE_LSB]),
        .mode_code(act_conv_reg[arcfg_pkg::MODE_MSB:arcfg_pkg::MODE_LSB]),
        .exc_code(act_ref_reg[arcfg_pkg::EXC_MSB:arcfg_pkg::EXC_LSB]),
        .rate_q(rate_q),
        .exc_ua(exc_ua),
        .code_bad(code_bad)
    );

    // decoded outputs, registered
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RATE_SEL <= 3'h0;
            OP_MODE <= 2'h0;
            RATE_QSPS <= 16'h0000;
            RATE_SCALED <= 1'b0;
            MOD_CLK_FAST <= 1'b0;
            DUTY_CYCLE_ON <= 1'b0;
            CONT_CONV <= 1'b0;
            TEMP_SENSE <= 1'b0;
            USE_MUX_CFG <= 1'b1;
            BURNOUT_ON <= 1'b0;
            BURNOUT_UA <= 11'h000;
            REF_SEL <= 2'h0;
            FORCE_INT_REF <= 1'b0;
            LINE_REJ <= 2'h0;
            EXC_UA_OUT <= 11'h000;
            CFG_INVALID <= 1'b0;
            REJ_MISUSE <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            RATE_SEL <= act_conv_reg[arcfg_pkg::RATE_MSB:arcfg_pkg::RATE_LSB];
            OP_MODE <= act_conv_reg[arcfg_pkg::MODE_MSB:arcfg_pkg::MODE_LSB];
            RATE_QSPS <= rate_q;
            RATE_SCALED <= EXT_CLK_SEL && (EXT_CLK_KHZ != arcfg_pkg::REF_CLK_KHZ);
            MOD_CLK_FAST <= act_conv_reg[arcfg_pkg::MODE_MSB:arcfg_pkg::MODE_LSB] == arcfg_pkg::MODE_TURBO;
            DUTY_CYCLE_ON <= act_conv_reg[arcfg_pkg::MODE_MSB:arcfg_pkg::MODE_LSB] == arcfg_pkg::MODE_DUTY;
            CONT_CONV <= act_conv_reg[arcfg_pkg::KIND_BIT];
            TEMP_SENSE <= act_conv_reg[arcfg_pkg::TEMP_BIT];
            USE_MUX_CFG <= !act_conv_reg[arcfg_pkg::TEMP_BIT];
            FORCE_INT_REF <= act_conv_reg[arcfg_pkg::TEMP_BIT];
            BURNOUT_ON <= act_conv_reg[arcfg_pkg::BURN_BIT];
            BURNOUT_UA <= act_conv_reg[arcfg_pkg::BURN_BIT] ? arcfg_pkg::BURNOUT_UA : 11'h000;
            REF_SEL <= act_conv_reg[arcfg_pkg::TEMP_BIT] ? 2'h0 : act_ref_reg[arcfg_pkg::REF_MSB:arcfg_pkg::REF_LSB];
            LINE_REJ <= act_ref_reg[arcfg_pkg::REJ_MSB:arcfg_pkg::REJ_LSB];
            EXC_UA_OUT <= exc_ua;
            CFG_INVALID <= code_bad;
            REJ_MISUSE <= (act_ref_reg[arcfg_pkg::REJ_MSB:arcfg_pkg::REJ_LSB] != 2'h0) &&
                          !((act_conv_reg[arcfg_pkg::RATE_MSB:arcfg_pkg::RATE_LSB] == 3'h0) &&
                            ((act_conv_reg[arcfg_pkg::MODE_MSB:arcfg_pkg::MODE_LSB] == arcfg_pkg::MODE_NORMAL) ||
                             (act_conv_reg[arcfg_pkg::MODE_MSB:arcfg_pkg::MODE_LSB] == arcfg_pkg::MODE_DUTY)));
            BUSY <= busy_reg;
        end
    end
endmodule // arcfg_regs

// >>> arcfg_conv_model.sv
// conversion engine model issuing begin, sleep and done pulses
module arcfg_conv_model #(
    parameter int LAT = 20
) (
    input wire logic CLK, // clock
    input wire logic SYS_RST, // async reset
    input wire logic go, // bench asks for a conversion
    input wire logic stop, // bench asks for sleep
    output logic begin_p, // begin pulse
    output logic sleep_p, // sleep pulse
    output logic done_p // conversion finished
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            begin_p <= 1'b0;
            sleep_p <= 1'b0;
            done_p <= 1'b0;
            cnt <= 0;
        end else begin
            begin_p <= go;
            sleep_p <= stop;
            done_p <= (cnt == 1);
            cnt <= go ? LAT : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule // arcfg_conv_model

// >>> arcfg_regs_sva.sv
// protocol and decode checks on the configuration block ports
module arcfg_regs_sva (
    input wire logic CLK, // clock
    input wire logic SYS_RST, // reset
    input wire logic [1:0] AVS_ADDRESS, // address
    input wire logic AVS_READ, // read
    input wire logic AVS_WRITE, // write
    input wire logic [31:0] AVS_READDATA, // read data
    input wire logic AVS_WAITREQUEST, // wait
    input wire logic AVS_RESPONSE_ERR, // error
    input wire logic CONV_BEGIN, // begin pulse
    input wire logic SLEEP_CMD, // sleep pulse
    input wire logic USE_MUX_CFG, // mux honoured
    input wire logic TEMP_SENSE, // temp mode
    input wire logic [1:0] REF_SEL, // reference
    input wire logic BURNOUT_ON, // burn-out on
    input wire logic [10:0] BURNOUT_UA, // burn-out uA
    input wire logic [1:0] OP_MODE, // mode
    input wire logic MOD_CLK_FAST, // turbo clock
    input wire logic DUTY_CYCLE_ON, // duty mode
    input wire logic LOWSIDE_CLOSED, // switch
    input wire logic BUSY // converting
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic req;
    assign req = AVS_READ || AVS_WRITE;
    one_wait_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("no answer one cycle after request");
    wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("wait low longer than one cycle");
    rdata_upper_a: assert property (AVS_READDATA[31:8] == 24'h0)
        else $error("upper read data not zero");
    err_unmapped_a: assert property (req && !AVS_WAITREQUEST |-> AVS_RESPONSE_ERR == (AVS_ADDRESS inside {0, 3}))
        else $error("error response wrong for address");
    mux_ignored_a: assert property (USE_MUX_CFG == !TEMP_SENSE && (TEMP_SENSE -> REF_SEL == 2'h0))
        else $error("temp mode not overriding mux or reference");
    burnout_mag_a: assert property (BURNOUT_UA == (BURNOUT_ON ? 11'h00a : 11'h000))
        else $error("burn-out magnitude wrong");
    mode_flags_a: assert property (MOD_CLK_FAST == (OP_MODE == 2'h2) && DUTY_CYCLE_ON == (OP_MODE == 2'h1))
        else $error("mode flags disagree with mode");
    sleep_opens_a: assert property (SLEEP_CMD |-> ##[1:2] !LOWSIDE_CLOSED && !BUSY)
        else $error("sleep left switch closed or busy");
    begin_busy_a: assert property (CONV_BEGIN && !SLEEP_CMD |-> ##[1:2] BUSY)
        else $error("begin did not start conversion");
    cover property (req && AVS_RESPONSE_ERR);
    cover property (CONV_BEGIN ##[1:4] LOWSIDE_CLOSED);
    cover property (TEMP_SENSE && BURNOUT_ON);
endmodule // arcfg_regs_sva
bind arcfg_regs arcfg_regs_sva i_sva (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE_ERR(AVS_RESPONSE_ERR), .CONV_BEGIN(CONV_BEGIN),
    .SLEEP_CMD(SLEEP_CMD), .USE_MUX_CFG(USE_MUX_CFG), .TEMP_SENSE(TEMP_SENSE), .REF_SEL(REF_SEL),
    .BURNOUT_ON(BURNOUT_ON), .BURNOUT_UA(BURNOUT_UA), .OP_MODE(OP_MODE), .MOD_CLK_FAST(MOD_CLK_FAST),
    .DUTY_CYCLE_ON(DUTY_CYCLE_ON), .LOWSIDE_CLOSED(LOWSIDE_CLOSED), .BUSY(BUSY));

// >>> arcfg_regs_tb.sv
// self-checking bench for the rate and reference configuration block
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module arcfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ext = 1'b0, go = 1'b0, stop = 1'b0;
    logic [1:0] addr = 2'h0, om, refs, lrej;
    logic [31:0] wdat = 32'h0, rdata, q;
    logic [3:0] ben = 4'h0;
    logic waitr, rs, mf, dc, cc, tse, um, bo, fi, lc, inv, mis, cb, sc, cd, qe, re, bsy;
    logic [2:0] rsel;
    logic [15:0] qsps, ex;
    logic [10:0] exc, bua;
    logic [15:0] nq [7] = '{16'h0050, 16'h00b4, 16'h0168, 16'h02bc, 16'h0528, 16'h0960, 16'h0fa0};
    logic [15:0] dq [7] = '{16'h0014, 16'h002d, 16'h005a, 16'h00b0, 16'h014a, 16'h0258, 16'h03e8};
    logic [10:0] eu [8] = '{11'h000, 11'h000, 11'h032, 11'h064, 11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc};
    int errors = 0, num_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    arcfg_conv_model #(.LAT(20)) i_eng (.CLK(clk), .SYS_RST(rst), .go(go), .stop(stop),
        .begin_p(cb), .sleep_p(sc), .done_p(cd));
    arcfg_regs #(.EXT_CLK_KHZ(8192)) i_dut (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(ben), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitr), .AVS_RESPONSE_ERR(re), .EXT_CLK_SEL(ext), .CONV_BEGIN(cb), .SLEEP_CMD(sc),
        .CONV_DONE(cd), .RATE_SEL(rsel), .OP_MODE(om), .RATE_QSPS(qsps), .RATE_SCALED(rs), .MOD_CLK_FAST(mf),
        .DUTY_CYCLE_ON(dc), .CONT_CONV(cc), .TEMP_SENSE(tse), .USE_MUX_CFG(um), .BURNOUT_ON(bo),
        .BURNOUT_UA(bua), .REF_SEL(refs), .FORCE_INT_REF(fi), .LINE_REJ(lrej), .LOWSIDE_CLOSED(lc),
        .EXC_UA_OUT(exc), .CFG_INVALID(inv), .REJ_MISUSE(mis), .BUSY(bsy));
    task automatic complete_run();
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // holds the request until wait is sampled low, then settles
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d, input logic [3:0] be);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        ben <= be;
        @(posedge clk);
        while (waitr !== 1'b0) @(posedge clk);
        q = rdata;
        qe = re;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // an inout copy would never reach the model, so drive the bench signals directly
    task automatic pulse(input logic to_sleep);
        go <= !to_sleep;
        stop <= to_sleep;
        @(posedge clk);
        go <= 1'b0;
        stop <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(0, 2'h1, 8'h00, 4'h1); `CHK({qe, q}, {1'b0, 32'h0})
        acc(1, 2'h2, 8'ha5, 4'h1);
        acc(1, 2'h2, 8'h5a, 4'he);
        acc(0, 2'h2, 8'h00, 4'h1); `CHK(q, 32'ha5)
        acc(1, 2'h3, 8'hff, 4'hf);
        acc(0, 2'h3, 8'h00, 4'hf); `CHK({qe, q}, {1'b1, 32'h0})
        acc(1, 2'h2, 8'h00, 4'h1);
        for (int m = 0; m < 3; m++) begin
            for (int r = 0; r < 7; r++) begin
                acc(1, 2'h1, {r[2:0], m[1:0], 3'h0}, 4'h1);
                ex = m == 1 ? dq[r] : (m == 2 ? {nq[r][14:0], 1'b0} : nq[r]);
                `CHK({qsps, rsel, om, mf, dc}, {ex, r[2:0], m[1:0], m == 2, m == 1})
            end
        end
        // host keeps to defined codes, so the invalid flag must stay low
        acc(1, 2'h1, 8'hd0, 4'h1); `CHK({inv, qsps}, 17'h01f40)
        acc(1, 2'h1, 8'h08, 4'h1); `CHK({inv, qsps}, 17'h00014)
        acc(1, 2'h2, 8'hc0, 4'h1);
        acc(1, 2'h1, 8'h07, 4'h1); `CHK({cc, tse, um, bo, refs, fi, bua}, {7'b1101001, 11'h00a})
        acc(1, 2'h1, 8'h00, 4'h1); `CHK({tse, refs}, 3'h3)
        for (int i = 0; i < 8; i++) begin
            acc(1, 2'h2, {i[1:0], i[1:0], 1'b0, ((i == 1) ? 3'h0 : i[2:0])}, 4'h1);
            `CHK({exc, refs, lrej, inv}, {eu[i], i[1:0], i[1:0], 1'b0})
        end
        // rejection kept only with rate code 0 in normal or duty-cycle mode
        acc(1, 2'h1, 8'h08, 4'h1); `CHK(mis, 1'b0)
        acc(1, 2'h2, 8'h08, 4'h1);
        pulse(1'b0); `CHK({lc, bsy}, 2'b11)
        pulse(1'b1); `CHK({lc, bsy}, 2'b00)
        acc(1, 2'h1, 8'h00, 4'h1);
        pulse(1'b0);
        acc(1, 2'h1, 8'hc0, 4'h1); `CHK({rsel, bsy}, 4'h1)
        repeat (24) @(posedge clk); `CHK({rsel, bsy}, 4'hc)
        ext <= 1'b1;
        repeat (4) @(posedge clk); `CHK(rs, 1'b1)
        complete_run();
    end
endmodule // arcfg_regs_tb
